// ==== rtl/io_irq_cfg.svh ====
`ifndef IO_IRQ_CFG_SVH
`define IO_IRQ_CFG_SVH

// byte addresses of the register map
`define ADDR_OUT_WRITE_EN    32'h400E0EA0
`define ADDR_OUT_WRITE_DIS   32'h400E0EA4
`define ADDR_OUT_WRITE_STATE 32'h400E0EA8
`define ADDR_OUT_LEVEL       32'h400E0EAC
`define ADDR_MODE_EN         32'h400E0EB0
`define ADDR_MODE_DIS        32'h400E0EB4
`define ADDR_MODE_STATE      32'h400E0EB8
`define ADDR_EDGE_SEL        32'h400E0EC0
`define ADDR_LEVEL_SEL       32'h400E0EC4
`define ADDR_EDGE_LEVEL      32'h400E0EC8
`define ADDR_FALL_LOW_SEL    32'h400E0ED0
`define ADDR_RISE_HIGH_SEL   32'h400E0ED4
`define ADDR_POLARITY        32'h400E0ED8
`define ADDR_LOCK_STATE      32'h400E0EE0
`define ADDR_IRQ_STATUS      32'h400E0EF0
`define ADDR_IRQ_CLEAR       32'h400E0EF4
`define ADDR_IRQ_ENABLE      32'h400E0EF8

// reset values
`define RST_WORD 32'h00000000

// bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/io_irq_pkg.sv ====
package io_irq_pkg;

  // per-line interrupt condition selection
  typedef struct packed {
    logic [31:0] extra;
    logic [31:0] level;
    logic [31:0] rise;
  } line_cfg_t;

  // a write taken from the bus
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } bus_write_t;

  typedef enum logic [1:0] {
    WR_COLLECT,
    WR_RESPOND
  } wr_state_t;

  typedef enum logic {
    RD_IDLE,
    RD_RESPOND
  } rd_state_t;

endpackage

// ==== rtl/io_line_irq_mode.sv ====
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "io_irq_cfg.svh"

module io_line_irq_mode #(
  parameter int LINES = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and neighbours
  input wire logic [LINES-1:0] line_in,
  input wire logic [LINES-1:0] line_locked,
  output logic [LINES-1:0] line_out,
  output logic [LINES-1:0] line_event,
  output logic irq
);

  if (LINES < 1 || LINES > 32) begin : g_bad_lines
    $error("LINES must lie between 1 and 32");
  end

  // true for every address that holds a register
  function automatic logic known_addr(input logic [31:0] a);
    known_addr = a == `ADDR_OUT_WRITE_EN || a == `ADDR_OUT_WRITE_DIS ||
                 a == `ADDR_OUT_WRITE_STATE || a == `ADDR_OUT_LEVEL ||
                 a == `ADDR_MODE_EN || a == `ADDR_MODE_DIS ||
                 a == `ADDR_MODE_STATE || a == `ADDR_EDGE_SEL ||
                 a == `ADDR_LEVEL_SEL || a == `ADDR_EDGE_LEVEL ||
                 a == `ADDR_FALL_LOW_SEL || a == `ADDR_RISE_HIGH_SEL ||
                 a == `ADDR_POLARITY || a == `ADDR_LOCK_STATE ||
                 a == `ADDR_IRQ_STATUS || a == `ADDR_IRQ_CLEAR ||
                 a == `ADDR_IRQ_ENABLE;
  endfunction

  // widen a line vector to a bus word, upper bits zero
  function automatic logic [31:0] to_word(input logic [LINES-1:0] v);
    to_word = `RST_WORD;
    for (int i = 0; i < LINES; i++) begin
      to_word[i] = v[i];
    end
  endfunction

  io_irq_pkg::line_cfg_t cfg;
  io_irq_pkg::bus_write_t wr;
  io_irq_pkg::wr_state_t wr_state;
  io_irq_pkg::rd_state_t rd_state;
  logic aw_held;
  logic w_held;
  logic wr_fire;
  logic [LINES-1:0] out_write_state;
  logic [LINES-1:0] lock_state;
  logic [LINES-1:0] line_prev;
  logic [LINES-1:0] irq_status;
  logic [LINES-1:0] irq_enable;
  logic [LINES-1:0] next_event;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // write side: address and data may arrive in either order
  assign wr_fire = wr_state == io_irq_pkg::WR_COLLECT && aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
      wr.addr <= `RST_WORD;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      wr.addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // strobes sampled with the data so the store sees the beat's own lanes
  logic [3:0] wr_strb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
      wr.data <= `RST_WORD;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      wr.data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // full-word stores only; partial strobes leave the bits alone
  logic [LINES-1:0] st;
  assign st = (&wr_strb) ? wr.data[LINES-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= io_irq_pkg::WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      case (wr_state)
        io_irq_pkg::WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= io_irq_pkg::WR_RESPOND;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_addr(wr.addr) ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        default: begin
          if (s_axi_bready) begin
            wr_state <= io_irq_pkg::WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // interrupt condition selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= {3{`RST_WORD}};
    end else if (wr_fire) begin
      if (wr.addr == `ADDR_MODE_EN) begin
        cfg.extra[LINES-1:0] <= cfg.extra[LINES-1:0] | st;
      end else if (wr.addr == `ADDR_MODE_DIS) begin
        cfg.extra[LINES-1:0] <= cfg.extra[LINES-1:0] & ~st;
      end else if (wr.addr == `ADDR_EDGE_SEL) begin
        cfg.level[LINES-1:0] <= cfg.level[LINES-1:0] & ~st;
      end else if (wr.addr == `ADDR_LEVEL_SEL) begin
        cfg.level[LINES-1:0] <= cfg.level[LINES-1:0] | st;
      end else if (wr.addr == `ADDR_FALL_LOW_SEL) begin
        cfg.rise[LINES-1:0] <= cfg.rise[LINES-1:0] & ~st;
      end else if (wr.addr == `ADDR_RISE_HIGH_SEL) begin
        cfg.rise[LINES-1:0] <= cfg.rise[LINES-1:0] | st;
      end
    end
  end

  // output write gating and output level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_write_state <= '0;
      line_out <= '0;
    end else if (wr_fire) begin
      if (wr.addr == `ADDR_OUT_WRITE_EN) begin
        out_write_state <= out_write_state | st;
      end else if (wr.addr == `ADDR_OUT_WRITE_DIS) begin
        out_write_state <= out_write_state & ~st;
      end else if (wr.addr == `ADDR_OUT_LEVEL && (&wr_strb)) begin
        line_out <= (line_out & ~out_write_state) | (st & out_write_state);
      end
    end
  end

  // condition evaluation, one cycle behind the pin
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      if (!cfg.extra[i]) begin
        next_event[i] = line_in[i] ^ line_prev[i];
      end else if (cfg.level[i]) begin
        next_event[i] = cfg.rise[i] ? line_in[i] : !line_in[i];
      end else begin
        next_event[i] = cfg.rise[i] ? (line_in[i] && !line_prev[i])
                                    : (!line_in[i] && line_prev[i]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // follow the pin in reset, so a line idling high shows no false edge
      line_prev <= line_in;
      line_event <= '0;
      lock_state <= '0;
    end else begin
      line_prev <= line_in;
      line_event <= next_event;
      lock_state <= line_locked;
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (wr_fire && wr.addr == `ADDR_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~st) | line_event;
    end else begin
      irq_status <= irq_status | line_event;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= '0;
    end else if (wr_fire && (&wr_strb) && wr.addr == `ADDR_IRQ_ENABLE) begin
      irq_enable <= st;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // read decode; write-only addresses read as zero
  always_comb begin
    next_rresp = `RESP_OKAY;
    if (s_axi_araddr == `ADDR_OUT_WRITE_STATE) begin
      next_rdata = to_word(out_write_state);
    end else if (s_axi_araddr == `ADDR_OUT_LEVEL) begin
      next_rdata = to_word(line_out);
    end else if (s_axi_araddr == `ADDR_MODE_STATE) begin
      next_rdata = to_word(cfg.extra[LINES-1:0]);
    end else if (s_axi_araddr == `ADDR_EDGE_LEVEL) begin
      next_rdata = to_word(cfg.level[LINES-1:0]);
    end else if (s_axi_araddr == `ADDR_POLARITY) begin
      next_rdata = to_word(cfg.rise[LINES-1:0]);
    end else if (s_axi_araddr == `ADDR_LOCK_STATE) begin
      next_rdata = to_word(lock_state);
    end else if (s_axi_araddr == `ADDR_IRQ_STATUS) begin
      next_rdata = to_word(irq_status);
    end else if (s_axi_araddr == `ADDR_IRQ_ENABLE) begin
      next_rdata = to_word(irq_enable);
    end else begin
      next_rdata = `RST_WORD;
      next_rresp = known_addr(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= io_irq_pkg::RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RST_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state)
        io_irq_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state <= io_irq_pkg::RD_RESPOND;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
          end
        end
        default: begin
          if (s_axi_rready) begin
            rd_state <= io_irq_pkg::RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_to(logic [31:0] a);
    wr_fire && wr.addr == a && (&wr_strb);
  endsequence

  sequence s_read_of(logic [31:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  a_mode_enable_sets: assert property (s_write_to(`ADDR_MODE_EN) |=>
    (cfg.extra[LINES-1:0] & $past(st)) == $past(st))
    else $error("mode enable did not set the line");
  a_mode_disable_clears: assert property (s_write_to(`ADDR_MODE_DIS) |=>
    (cfg.extra[LINES-1:0] & $past(st)) == '0)
    else $error("mode disable did not clear the line");
  a_mode_state_read: assert property (s_read_of(`ADDR_MODE_STATE) |=>
    s_axi_rvalid && s_axi_rdata == to_word($past(cfg.extra[LINES-1:0])))
    else $error("mode state read mismatch");
  a_edge_sel_clears: assert property (s_write_to(`ADDR_EDGE_SEL) |=>
    (cfg.level[LINES-1:0] & $past(st)) == '0 &&
    (cfg.level[LINES-1:0] & ~$past(st)) == ($past(cfg.level[LINES-1:0]) & ~$past(st)))
    else $error("edge select mishandled");
  a_level_sel_sets: assert property (s_write_to(`ADDR_LEVEL_SEL) |=>
    (cfg.level[LINES-1:0] & $past(st)) == $past(st))
    else $error("level select did not set the line");
  a_edge_level_read: assert property (s_read_of(`ADDR_EDGE_LEVEL) |=>
    s_axi_rdata == to_word($past(cfg.level[LINES-1:0])))
    else $error("edge/level read mismatch");
  a_fall_sel_clears: assert property (s_write_to(`ADDR_FALL_LOW_SEL) |=>
    (cfg.rise[LINES-1:0] & $past(st)) == '0)
    else $error("fall/low select did not clear polarity");
  a_rise_sel_sets: assert property (s_write_to(`ADDR_RISE_HIGH_SEL) |=>
    (cfg.rise[LINES-1:0] & $past(st)) == $past(st))
    else $error("rise/high select did not set polarity");
  // fixed lines keep these cheap; one line per condition kind
  if (LINES >= 5) begin : g_mode_checks
    a_rise_edge_event: assert property (cfg.extra[1] && !cfg.level[1] && cfg.rise[1] &&
      line_in[1] && !line_prev[1] |=> line_event[1])
      else $error("rising edge did not raise an event");
    a_fall_edge_event: assert property (cfg.extra[2] && !cfg.level[2] && !cfg.rise[2] &&
      !line_in[2] && line_prev[2] |=> line_event[2])
      else $error("falling edge did not raise an event");
    a_high_level_event: assert property (cfg.extra[3] && cfg.level[3] && cfg.rise[3] &&
      line_in[3] |=> line_event[3])
      else $error("high level did not raise an event");
    a_low_level_event: assert property (cfg.extra[4] && cfg.level[4] && !cfg.rise[4] &&
      !line_in[4] |=> line_event[4])
      else $error("low level did not raise an event");
  end
  a_lock_follows: assert property (line_locked == $past(line_locked, 1) [*2] |->
    lock_state == line_locked)
    else $error("lock state does not follow");
  a_both_edge_event: assert property (!cfg.extra[0] && $changed(line_in[0]) |=>
    line_event[0] ##1 irq_status[0])
    else $error("both-edge change lost");
  a_out_gated: assert property (s_write_to(`ADDR_OUT_LEVEL) |=>
    ((line_out ^ $past(line_out)) & ~$past(out_write_state)) == '0)
    else $error("output changed on a gated line");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_event_beats_clear: assert property (wr_fire && wr.addr == `ADDR_IRQ_CLEAR |=>
    (irq_status & $past(line_event)) == $past(line_event))
    else $error("event lost to a status clear");
  a_irq_follows: assert property (1'b1 |=> irq == |($past(irq_status) & $past(irq_enable)))
    else $error("interrupt output does not follow status");

endmodule // io_line_irq_mode

`default_nettype wire

// ==== dv/io_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module io_pin_model (
  // clock
  input wire logic aclk,
  // levels towards the block
  output logic [31:0] line_in,
  output logic [31:0] line_locked
);
  initial begin
    line_in = 32'h0;
    line_locked = 32'h0;
  end

  // pins move just after an edge, so the block never sees a change on its sampling edge
  task automatic set_pins(input logic [31:0] v);
    @(posedge aclk);
    line_in <= v;
  endtask

  task automatic set_lock(input logic [31:0] v);
    @(posedge aclk);
    line_locked <= v;
  endtask
endmodule // io_pin_model

`default_nettype wire

// ==== dv/io_line_irq_mode_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "io_irq_cfg.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end

module io_line_irq_mode_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, line_in, line_locked, line_out, line_event;
  logic [31:0] seen = 32'h0;
  logic seen_clr = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;

  always #5 aclk = ~aclk;

  // events may be one-cycle pulses, so they are gathered rather than sampled once
  always @(posedge aclk) seen <= seen_clr ? 32'h0 : (seen | line_event);

  io_pin_model pins (.aclk(aclk), .line_in(line_in), .line_locked(line_locked));

  io_line_irq_mode #(.LINES(32)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_in(line_in), .line_locked(line_locked), .line_out(line_out),
    .line_event(line_event), .irq(irq)
  );

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
    bit ad, wd, bd;
    ad = 0;
    wd = 0;
    bd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bd = 1;
        bready <= 1'b0;
        `CHK(bresp, er)
      end
    end
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                        input logic [1:0] er = `RESP_OKAY);
    bit ad, dn;
    logic [31:0] d;
    logic [1:0] r;
    ad = 0;
    dn = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        dn = 1;
        rready <= 1'b0;
        d = rdata;
        r = rresp;
      end
    end
    `CHK(d, exp)
    `CHK(r, er)
  endtask

  // masked lines are excluded because a level condition may still fire while the pins move
  task automatic ev_chk(input logic [31:0] v, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge aclk);
    seen_clr <= 1'b1;
    @(posedge aclk);
    seen_clr <= 1'b0;
    pins.set_pins(v);
    repeat (6) @(posedge aclk);
    `CHK(seen & mask, exp)
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`ADDR_MODE_STATE, 32'h0);
    rd_chk(`ADDR_EDGE_LEVEL, 32'h0);
    rd_chk(`ADDR_POLARITY, 32'h0);
    rd_chk(`ADDR_OUT_WRITE_STATE, 32'h0);
    // line 0 stays both-edge, lines 1..4 take the extra mode
    wr(`ADDR_MODE_EN, 32'h8000001E);
    wr(`ADDR_MODE_EN, 32'h0);
    rd_chk(`ADDR_MODE_STATE, 32'h8000001E);
    wr(`ADDR_MODE_DIS, 32'h80000000);
    wstrb <= 4'h3;
    wr(`ADDR_MODE_DIS, 32'hFFFFFFFF);
    wstrb <= 4'hF;
    wr(`ADDR_MODE_STATE, 32'h0);
    rd_chk(`ADDR_MODE_STATE, 32'h0000001E);
    wr(`ADDR_LEVEL_SEL, 32'h00000019);
    wr(`ADDR_EDGE_SEL, 32'h00000001);
    wr(`ADDR_EDGE_SEL, 32'h0);
    rd_chk(`ADDR_EDGE_LEVEL, 32'h00000018);
    rd_chk(`ADDR_LEVEL_SEL, 32'h0);
    wr(`ADDR_RISE_HIGH_SEL, 32'h0000000B);
    wr(`ADDR_FALL_LOW_SEL, 32'h00000001);
    wr(`ADDR_RISE_HIGH_SEL, 32'h0);
    rd_chk(`ADDR_POLARITY, 32'h0000000A);
    // 1 rise, 2 fall, 3 high level, 4 low level
    ev_chk(32'h0000001F, 32'hFFFFFFEF, 32'h0000000B);
    ev_chk(32'h0, 32'hFFFFFFF7, 32'h00000015);
    wr(`ADDR_MODE_DIS, 32'hFFFFFFFF);
    rd_chk(`ADDR_MODE_STATE, 32'h0);
    wr(`ADDR_IRQ_CLEAR, 32'hFFFFFFFF);
    rd_chk(`ADDR_IRQ_STATUS, 32'h0);
    wr(`ADDR_IRQ_ENABLE, 32'h00000002);
    rd_chk(`ADDR_IRQ_ENABLE, 32'h00000002);
    `CHK(irq, 1'b0)
    ev_chk(32'h00000002, 32'hFFFFFFFF, 32'h00000002);
    ev_chk(32'h0, 32'hFFFFFFFF, 32'h00000002);
    `CHK(irq, 1'b1)
    rd_chk(`ADDR_IRQ_STATUS, 32'h00000002);
    // a partial-strobe store must leave the enable alone
    wstrb <= 4'h3;
    wr(`ADDR_IRQ_ENABLE, 32'h0);
    wstrb <= 4'hF;
    rd_chk(`ADDR_IRQ_ENABLE, 32'h00000002);
    wr(`ADDR_IRQ_ENABLE, 32'h0);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(`ADDR_IRQ_ENABLE, 32'h00000002);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(`ADDR_IRQ_CLEAR, 32'h00000002);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd_chk(`ADDR_IRQ_STATUS, 32'h0);
    wr(`ADDR_OUT_WRITE_EN, 32'h000000FF);
    wr(`ADDR_OUT_WRITE_DIS, 32'h0000000F);
    rd_chk(`ADDR_OUT_WRITE_STATE, 32'h000000F0);
    wr(`ADDR_OUT_LEVEL, 32'hFFFFFFFF);
    `CHK(line_out, 32'h000000F0)
    pins.set_lock(32'hA5000003);
    repeat (2) @(posedge aclk);
    rd_chk(`ADDR_LOCK_STATE, 32'hA5000003);
    wr(32'h400E0EFC, 32'h00000001, `RESP_SLVERR);
    rd_chk(32'h400E0EFC, 32'h0, `RESP_SLVERR);
    // second reset in mid-run brings the configuration back to both-edge
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`ADDR_OUT_WRITE_STATE, 32'h0);
    rd_chk(`ADDR_EDGE_LEVEL, 32'h0);
    rd_chk(`ADDR_IRQ_ENABLE, 32'h0);
    rd_chk(`ADDR_LOCK_STATE, 32'hA5000003);
    tally_and_finish();
  end
endmodule // io_line_irq_mode_tb

`default_nettype wire
